// *** rtl/tfc_top.sv ***
// Contract
// - Record drives are complements, never both active.
// - Low neg drive gives negative flux; active pos drive positive flux.
// - CPU serial frames: start, eight data, stop, no parity.
// - Bytes become FM code on an internal 2.4 kHz cell clock.
// - Flux polarity toggles at every cell clock edge.
// - Zero bit adds a mid-cell toggle; one bit does not.
// - Playback data separated from cell clock, sent to CPU receive.
// - VCO gets read pulses with zero mid-cell pulses removed.
// - VCO output divided by eight feeds VCO phase reference.
// - Separation timing follows the VCO output, tracking tape speed.
// - Audio record line held low throughout audio recording.
// - Phone record: mic select high, phone low; mic record: mic low.
// - Not recording: mic, phone and audio record lines all high.
// - Phone path selects tape, mic or tones, active low.
// - Phone path unused: phone path off line driven low.
// - Speaker path selects tape, phone or tones, active low.
// - No speaker audio: speaker path off line driven low.
`timescale 1ns/10ps
`default_nettype none

module tfc_top #(
  parameter logic [15:0] HALF_CELL_CYC = 16'(tfc_pkg::HALF_CELL_CYC)
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic             o_wb_ack,
  output logic      [31:0] o_wb_dat,
  input  wire logic        i_cpu_serial_tx,
  output logic             o_cpu_serial_rx,
  output logic             o_write_drive_neg,
  output logic             o_write_drive_pos,
  input  wire logic        i_read_edge_pulses,
  input  wire logic        i_vco_out,
  output logic             o_vco_signal,
  output logic             o_vco_phase_ref,
  output logic             o_audio_record_n,
  output logic             o_mic_to_tape_n,
  output logic             o_phone_to_tape_n,
  output logic             o_tape_to_phone_n,
  output logic             o_mic_to_phone_n,
  output logic             o_tones_to_phone_n,
  output logic             o_phone_path_off_n,
  output logic             o_tape_to_spkr_n,
  output logic             o_phone_to_spkr_n,
  output logic             o_tones_to_spkr_n,
  output logic             o_spkr_path_off_n
);

  logic [2:0] pins_sync;
  logic       tx_s;
  logic       pulse_s;
  logic       vco_s;
  logic       enc_busy;

  tfc_sync #(.W(3)) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async ({i_cpu_serial_tx, i_read_edge_pulses, i_vco_out}),
    .o_sync  (pins_sync)
  );
  // Synced tx resets low; encoder is parked until enabled anyway
  assign tx_s    = pins_sync[2];
  assign pulse_s = pins_sync[1];
  assign vco_s   = pins_sync[0];

  // Wishbone slave
  logic [7:0]  ctrl_reg, ctrl_next;
  logic        ack_reg,  ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic        req;
  logic        rx_reg;
  logic        carrier;

  assign req = i_wb_cyc && i_wb_stb && !ack_reg;

  always_comb begin
    ctrl_next = ctrl_reg;
    ack_next  = req;
    rdat_next = rdat_reg;
    if (req) begin
      rdat_next = 32'h0000_0000;
      if (i_wb_adr == tfc_pkg::ADDR_CTRL) begin
        rdat_next[7:0] = ctrl_reg;
        if (i_wb_we && i_wb_sel[0]) begin
          ctrl_next = i_wb_dat[7:0];
        end
      end else if (i_wb_adr == tfc_pkg::ADDR_STAT) begin
        rdat_next[tfc_pkg::STAT_ENC_BUSY] = enc_busy;
        rdat_next[tfc_pkg::STAT_RX_BIT]   = rx_reg;
        rdat_next[tfc_pkg::STAT_CARRIER]  = carrier;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_reg <= tfc_pkg::CTRL_RESET;
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      ack_reg  <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;

  // Frame bits pass cell by cell at cell rate
  tfc_fm_enc #(.HALF_CYC(HALF_CELL_CYC)) u_enc (
    .i_clk             (i_clk),
    .i_rst_n           (i_rst_n),
    .i_enable          (ctrl_reg[tfc_pkg::CTRL_DATA_REC]),
    .i_bit             (tx_s),
    .o_write_drive_neg (o_write_drive_neg),
    .o_write_drive_pos (o_write_drive_pos),
    .o_busy            (enc_busy)
  );

  // Playback separator, timed by VCO ticks not the system clock
  logic       vco_d_reg,   vco_d_next;
  logic       pls_d_reg,   pls_d_next;
  logic [2:0] div_reg,     div_next;
  logic [4:0] ticks_reg,   ticks_next;
  logic       mid_reg,     mid_next;
  logic       rx_next;
  logic       sig_reg,     sig_next;
  logic       tick;
  logic       edge_p;

  assign tick    = vco_s && !vco_d_reg;
  assign edge_p  = pulse_s && !pls_d_reg;
  assign carrier = (ticks_reg != tfc_pkg::IDLE_TICKS);

  always_comb begin
    vco_d_next = vco_s;
    pls_d_next = pulse_s;
    div_next   = div_reg;
    ticks_next = ticks_reg;
    mid_next   = mid_reg;
    rx_next    = rx_reg;
    sig_next   = sig_reg;
    if (tick) begin
      div_next = (div_reg == tfc_pkg::VCO_DIV_LAST) ? 3'h0
                                                    : div_reg + 3'h1;
      sig_next = 1'b0;
      // Cell timing counted in VCO ticks
      if (ticks_reg != tfc_pkg::IDLE_TICKS) begin
        ticks_next = ticks_reg + 5'h01;
      end
      if (ticks_reg == tfc_pkg::IDLE_TICKS - 5'h01) begin
        rx_next  = 1'b1;
        mid_next = 1'b0;
      end
    end
    if (edge_p) begin
      if (ticks_reg >= tfc_pkg::CLK_MIN_TICKS) begin
        // Clock pulse closes cell, bit to CPU
        rx_next    = !mid_reg;
        mid_next   = 1'b0;
        ticks_next = 5'h00;
        // Only clock pulses reach the VCO
        sig_next   = 1'b1;
      end else if (ticks_reg >= tfc_pkg::MID_MIN_TICKS) begin
        mid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      vco_d_reg <= 1'b0;
      pls_d_reg <= 1'b0;
      div_reg   <= 3'h0;
      ticks_reg <= tfc_pkg::IDLE_TICKS;
      mid_reg   <= 1'b0;
      rx_reg    <= 1'b1;
      sig_reg   <= 1'b0;
    end else begin
      vco_d_reg <= vco_d_next;
      pls_d_reg <= pls_d_next;
      div_reg   <= div_next;
      ticks_reg <= ticks_next;
      mid_reg   <= mid_next;
      rx_reg    <= rx_next;
      sig_reg   <= sig_next;
    end
  end

  assign o_cpu_serial_rx = rx_reg;
  assign o_vco_signal    = sig_reg;
  assign o_vco_phase_ref = div_reg[2];

  // Audio multiplexer selects, registered off the control word
  logic [10:0] aud_reg, aud_next;
  tfc_pkg::tfc_src_t phone_src, spkr_src;

  assign phone_src =
    tfc_pkg::tfc_src_t'(ctrl_reg[tfc_pkg::CTRL_PHONE_LO +: 2]);
  assign spkr_src  = tfc_pkg::tfc_src_t'(ctrl_reg[tfc_pkg::CTRL_SPKR_LO +: 2]);

  always_comb begin
    aud_next = 11'h7ff;
    if (ctrl_reg[tfc_pkg::CTRL_AUDIO_REC]) begin
      aud_next[10] = 1'b0;
      aud_next[9]  = ctrl_reg[tfc_pkg::CTRL_REC_PHONE] ? 1'b1 : 1'b0;
      aud_next[8]  = ctrl_reg[tfc_pkg::CTRL_REC_PHONE] ? 1'b0 : 1'b1;
    end
    // One phone source at a time
    unique case (phone_src)
      tfc_pkg::SRC_OFF:   aud_next[4] = 1'b0;
      tfc_pkg::SRC_TAPE:  aud_next[7] = 1'b0;
      tfc_pkg::SRC_ALT:   aud_next[6] = 1'b0;
      tfc_pkg::SRC_TONES: aud_next[5] = 1'b0;
    endcase
    // One speaker source at a time
    unique case (spkr_src)
      tfc_pkg::SRC_OFF:   aud_next[0] = 1'b0;
      tfc_pkg::SRC_TAPE:  aud_next[3] = 1'b0;
      tfc_pkg::SRC_ALT:   aud_next[2] = 1'b0;
      tfc_pkg::SRC_TONES: aud_next[1] = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      // Idle after reset: all record lines high
      aud_reg <= 11'h7ee;
    end else begin
      aud_reg <= aud_next;
    end
  end

  assign o_audio_record_n   = aud_reg[10];
  assign o_mic_to_tape_n    = aud_reg[9];
  assign o_phone_to_tape_n  = aud_reg[8];
  assign o_tape_to_phone_n  = aud_reg[7];
  assign o_mic_to_phone_n   = aud_reg[6];
  assign o_tones_to_phone_n = aud_reg[5];
  assign o_phone_path_off_n = aud_reg[4];
  assign o_tape_to_spkr_n   = aud_reg[3];
  assign o_phone_to_spkr_n  = aud_reg[2];
  assign o_tones_to_spkr_n  = aud_reg[1];
  assign o_spkr_path_off_n  = aud_reg[0];

  property p_rec_idle;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_audio_record_n |-> (o_mic_to_tape_n && o_phone_to_tape_n);
  endproperty
  a_rec_idle: assert property (p_rec_idle)
    else $error("record select active while not recording");

  property p_rec_on;
    @(posedge i_clk) disable iff (!i_rst_n)
      ctrl_reg[tfc_pkg::CTRL_AUDIO_REC] |=> !o_audio_record_n;
  endproperty
  a_rec_on: assert property (p_rec_on)
    else $error("audio record line not low while recording");

  property p_rec_src;
    @(posedge i_clk) disable iff (!i_rst_n)
      !o_audio_record_n |-> (o_mic_to_tape_n != o_phone_to_tape_n);
  endproperty
  a_rec_src: assert property (p_rec_src)
    else $error("record source not exactly one");

  property p_phone_sel;
    @(posedge i_clk) disable iff (!i_rst_n)
      $countones({o_tape_to_phone_n, o_mic_to_phone_n,
                  o_tones_to_phone_n, o_phone_path_off_n}) == 3;
  endproperty
  a_phone_sel: assert property (p_phone_sel)
    else $error("phone path selects not one-hot low");

  property p_spkr_sel;
    @(posedge i_clk) disable iff (!i_rst_n)
      (spkr_src == tfc_pkg::SRC_OFF) |=> (!o_spkr_path_off_n &&
        o_tape_to_spkr_n && o_phone_to_spkr_n && o_tones_to_spkr_n);
  endproperty
  a_spkr_sel: assert property (p_spkr_sel)
    else $error("speaker path not off when unused");

  property p_div8;
    @(posedge i_clk) disable iff (!i_rst_n)
      (tick && div_reg == tfc_pkg::VCO_DIV_LAST) |=> (div_reg == 3'h0);
  endproperty
  a_div8: assert property (p_div8)
    else $error("vco divider did not wrap after eight");

  property p_clk_pulse;
    @(posedge i_clk) disable iff (!i_rst_n)
      (edge_p && ticks_reg >= tfc_pkg::CLK_MIN_TICKS) |=>
        (o_vco_signal && ticks_reg == 5'h00 &&
         o_cpu_serial_rx == !$past(mid_reg));
  endproperty
  a_clk_pulse: assert property (p_clk_pulse)
    else $error("clock pulse not taken as cell boundary");

  property p_mid_drop;
    @(posedge i_clk) disable iff (!i_rst_n)
      (edge_p && !sig_reg && ticks_reg < tfc_pkg::CLK_MIN_TICKS) |=>
        !o_vco_signal;
  endproperty
  a_mid_drop: assert property (p_mid_drop)
    else $error("mid-cell pulse passed to vco");

  property p_ack_once;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("wishbone ack held two cycles");

endmodule : tfc_top

`default_nettype wire

// *** rtl/tfc_pkg.sv ***
package tfc_pkg;

  // Wishbone register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;

  // Control field positions
  localparam int CTRL_DATA_REC  = 0;
  localparam int CTRL_AUDIO_REC = 1;
  localparam int CTRL_REC_PHONE = 2;
  localparam int CTRL_PHONE_LO  = 4;
  localparam int CTRL_SPKR_LO   = 6;
  localparam int CTRL_W         = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status field positions
  localparam int STAT_ENC_BUSY = 0;
  localparam int STAT_RX_BIT   = 1;
  localparam int STAT_CARRIER  = 2;

  // Cell timing at 125 MHz, 2.4 kHz cells
  localparam int CLK_HZ  = 125000000;
  localparam int CELL_HZ = 2400;
  localparam int HALF_CELL_CYC = CLK_HZ / (2 * CELL_HZ);

  // VCO runs at eight ticks per cell
  localparam logic [2:0] VCO_DIV_LAST  = 3'h7;
  localparam logic [4:0] MID_MIN_TICKS = 5'h02;
  localparam logic [4:0] CLK_MIN_TICKS = 5'h06;
  localparam logic [4:0] IDLE_TICKS    = 5'h10;

  // Audio path source codes
  typedef enum logic [1:0] {
    SRC_OFF   = 2'b00,
    SRC_TAPE  = 2'b01,
    SRC_ALT   = 2'b10,
    SRC_TONES = 2'b11
  } tfc_src_t;

endpackage : tfc_pkg

// *** rtl/tfc_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module tfc_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;

  // Two flops per bit; the first is read only by the second
  genvar g;
  for (g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        s1_reg[g] <= 1'b0;
        s2_reg[g] <= 1'b0;
      end else begin
        s1_reg[g] <= i_async[g];
        s2_reg[g] <= s1_reg[g];
      end
    end
  end

  assign o_sync = s2_reg;

endmodule : tfc_sync

`default_nettype wire

// *** rtl/tfc_fm_enc.sv ***
`timescale 1ns/10ps
`default_nettype none

module tfc_fm_enc #(
  parameter logic [15:0] HALF_CYC = 16'(tfc_pkg::HALF_CELL_CYC)
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_enable,
  input  wire logic i_bit,
  output logic      o_write_drive_neg,
  output logic      o_write_drive_pos,
  output logic      o_busy
);

  logic [15:0] cnt_reg,  cnt_next;
  logic        half_reg, half_next;
  logic        bit_reg,  bit_next;
  logic        pol_reg,  pol_next;
  logic        pos_reg,  pos_next;
  logic        wrap;

  assign wrap = (cnt_reg == HALF_CYC - 16'h0001);

  always_comb begin
    cnt_next  = cnt_reg + 16'h0001;
    half_next = half_reg;
    bit_next  = bit_reg;
    pol_next  = pol_reg;
    if (!i_enable) begin
      // Parked so the first enabled cycle is a cell edge
      cnt_next  = HALF_CYC - 16'h0001;
      half_next = 1'b1;
      bit_next  = 1'b1;
      pol_next  = 1'b1;
    end else if (wrap) begin
      cnt_next  = 16'h0000;
      half_next = ~half_reg;
      if (half_reg) begin
        pol_next = ~pol_reg;
        bit_next = i_bit;
      end else if (!bit_reg) begin
        pol_next = ~pol_reg;
      end
    end
    pos_next = ~pol_next;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_reg  <= 16'h0000;
      half_reg <= 1'b1;
      bit_reg  <= 1'b1;
      pol_reg  <= 1'b1;
      pos_reg  <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      half_reg <= half_next;
      bit_reg  <= bit_next;
      pol_reg  <= pol_next;
      pos_reg  <= pos_next;
    end
  end

  // Low neg drive is negative flux
  assign o_write_drive_neg = pol_reg;
  assign o_write_drive_pos = pos_reg;
  assign o_busy            = i_enable;

  property p_enc_compl;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_write_drive_neg != o_write_drive_pos;
  endproperty
  a_enc_compl: assert property (p_enc_compl)
    else $error("record drives not complementary");

  property p_enc_edge;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_enable && wrap && half_reg) |=>
        (o_write_drive_neg != $past(o_write_drive_neg));
  endproperty
  a_enc_edge: assert property (p_enc_edge)
    else $error("no flux toggle at cell edge");

  property p_enc_zero;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_enable && wrap && !half_reg && !bit_reg) |=>
        $changed(o_write_drive_neg);
  endproperty
  a_enc_zero: assert property (p_enc_zero)
    else $error("zero bit missed mid-cell toggle");

  property p_enc_one;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_enable && !half_reg && bit_reg) |=>
        $stable(o_write_drive_neg);
  endproperty
  a_enc_one: assert property (p_enc_one)
    else $error("one bit toggled inside its cell");

endmodule : tfc_fm_enc

`default_nettype wire

// *** dv/tfc_tape_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module tfc_tape_model #(
  parameter int CELL_CYC = 40
) (
  input  wire logic i_clk,
  output logic      o_cpu_serial_tx,
  output logic      o_read_edge_pulses,
  output logic      o_vco_out
);
  // Eight VCO periods per cell; offset keeps edges off i_clk edges
  initial begin
    o_vco_out = 1'b0;
    #1;
    forever #20 o_vco_out = ~o_vco_out;
  end

  initial begin
    o_cpu_serial_tx    = 1'b1;
    o_read_edge_pulses = 1'b0;
  end

  task automatic send_frame(input logic [7:0] data);
    logic [9:0] frame;
    frame = {1'b1, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_cpu_serial_tx <= frame[i];
      repeat (CELL_CYC) @(posedge i_clk);
    end
    o_cpu_serial_tx <= 1'b1;
  endtask : send_frame

  task automatic pulse();
    o_read_edge_pulses <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_read_edge_pulses <= 1'b0;
  endtask : pulse

  // Caller has already spent skip cycles of this cell
  task automatic play_bit(input logic b, input int skip);
    if (!b) begin
      repeat (CELL_CYC / 2 - 2 - skip) @(posedge i_clk);
      pulse();
      repeat (CELL_CYC / 2 - 2) @(posedge i_clk);
    end else begin
      repeat (CELL_CYC - 2 - skip) @(posedge i_clk);
    end
    pulse();
  endtask : play_bit
endmodule : tfc_tape_model
`default_nettype wire

// *** dv/tfc_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module tfc_top_tb;
  // Short cells keep the run brief
  localparam int H    = 20;
  localparam int CELL = 2 * H;

  logic        clk, rst_n, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic        tx, rx, neg, pos, rdp, vco, vsig, pref;
  logic        aud_n, mtt_n, ptt_n;
  logic [3:0]  ph_n, sp_n;
  logic        pref_d, vsig_d;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          vsig_rises = 0;
  int          cyc_n = 0;
  int          pref_last = 0;
  int          pref_gap = 0;

  tfc_top #(.HALF_CELL_CYC(16'(H))) i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_ack(ack), .o_wb_dat(rdat), .i_cpu_serial_tx(tx),
    .o_cpu_serial_rx(rx), .o_write_drive_neg(neg),
    .o_write_drive_pos(pos), .i_read_edge_pulses(rdp), .i_vco_out(vco),
    .o_vco_signal(vsig), .o_vco_phase_ref(pref),
    .o_audio_record_n(aud_n), .o_mic_to_tape_n(mtt_n),
    .o_phone_to_tape_n(ptt_n), .o_tape_to_phone_n(ph_n[0]),
    .o_mic_to_phone_n(ph_n[1]), .o_tones_to_phone_n(ph_n[2]),
    .o_phone_path_off_n(ph_n[3]), .o_tape_to_spkr_n(sp_n[0]),
    .o_phone_to_spkr_n(sp_n[1]), .o_tones_to_spkr_n(sp_n[2]),
    .o_spkr_path_off_n(sp_n[3]));

  tfc_tape_model #(.CELL_CYC(CELL)) i_model (
    .i_clk(clk), .o_cpu_serial_tx(tx), .o_read_edge_pulses(rdp),
    .o_vco_out(vco));

  always #4 clk = ~clk;

  // Edge monitor for the VCO side outputs
  always @(posedge clk) begin
    pref_d <= pref;
    vsig_d <= vsig;
    cyc_n <= cyc_n + 1;
    if (pref === 1'b1 && pref_d === 1'b0) begin
      pref_gap <= cyc_n - pref_last;
      pref_last <= cyc_n;
    end
    if (vsig === 1'b1 && vsig_d === 1'b0) begin
      vsig_rises <= vsig_rises + 1;
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what,
               seen, exp);
    end
  endtask : check

  // Master holds the request until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // No cycle count assumed; the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, a, d, s, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, 4'hf, q);
  endtask : rd

  // Active-low one-hot, vector is {off, third, second, tape}
  function automatic logic [3:0] src_sel(input logic [1:0] s);
    return (s == 2'h0) ? 4'h7 : ~(4'h1 << (s - 2'h1));
  endfunction : src_sel

  task automatic t_reset();
    check({ack, rx, neg, pos, aud_n, mtt_n, ptt_n}, 7'h37, "rst");
    check({ph_n, sp_n}, 8'h77, "rst mux");
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    logic [31:0] q;
    wr(tfc_pkg::ADDR_CTRL, 32'h1234_56ce, 4'hf);
    rd(tfc_pkg::ADDR_CTRL, q);
    check(q, 32'hce, "ctrl rw");
    wr(tfc_pkg::ADDR_CTRL, 32'h11, 4'he);
    rd(tfc_pkg::ADDR_CTRL, q);
    check(q, 32'hce, "sel lane");
    wr(8'h08, 32'hff, 4'hf);
    rd(8'h08, q);
    check(q, 32'h0, "unmapped");
    wr(tfc_pkg::ADDR_STAT, 32'hff, 4'hf);
    rd(tfc_pkg::ADDR_STAT, q);
    check(q, 32'h2, "stat ro");
    $display("test regs done");
  endtask : t_regs

  task automatic t_audio();
    logic [1:0] p;
    logic [7:0] c;
    for (int i = 0; i < 4; i++) begin
      p = 2'(i);
      c = {~p, p, 1'b0, p[1], p[0], 1'b0};
      wr(tfc_pkg::ADDR_CTRL, {24'h0, c}, 4'hf);
      @(posedge clk);
      check({aud_n, mtt_n, ptt_n}, p[0] ? {1'b0, p[1], ~p[1]} : 3'h7,
            "rec sel");
      check(ph_n, src_sel(p), "phone mux");
      check(sp_n, src_sel(~p), "spkr mux");
    end
    $display("test audio done");
  endtask : t_audio

  task automatic t_enc();
    logic [31:0] q;
    logic        pn;
    int          last, nh, bad;
    last = -1;
    nh = 0;
    bad = 0;
    wr(tfc_pkg::ADDR_CTRL, 32'h1, 4'h1);
    rd(tfc_pkg::ADDR_STAT, q);
    check(q[0], 1'b1, "enc stat");
    pn = neg;
    fork
      begin
        repeat (2 * CELL) @(posedge clk);
        i_model.send_frame(8'h35);
      end
      for (int t = 0; t < 16 * CELL; t++) begin
        @(posedge clk);
        check(pos, {~neg}, "drive pair");
        if (neg !== pn) begin
          if (last >= 0 && t - last == H) nh++;
          else if (last >= 0 && t - last != CELL) bad++;
          last = t;
          pn = neg;
        end
      end
    join
    check(nh, 10, "mid toggles");
    check(bad, 0, "cell spacing");
    wr(tfc_pkg::ADDR_CTRL, 32'h0, 4'h1);
    repeat (3) @(posedge clk);
    check({neg, pos}, 2'h2, "park");
    $display("test encoder done");
  endtask : t_enc

  task automatic t_play();
    logic [31:0] q;
    logic [4:0]  bits;
    logic        eb;
    int          base;
    bits = 5'h09;
    eb = 1'b1;
    base = vsig_rises;
    i_model.pulse();
    for (int i = 0; i < 5; i++) begin
      repeat (8) @(posedge clk);
      check(rx, eb, "rx bit");
      i_model.play_bit(bits[i], 8);
      eb = bits[i];
    end
    repeat (8) @(posedge clk);
    check(rx, eb, "rx last");
    rd(tfc_pkg::ADDR_STAT, q);
    check(q, 32'h4, "carrier");
    repeat (120) @(posedge clk);
    check(rx, 1'b1, "rx idle");
    rd(tfc_pkg::ADDR_STAT, q);
    check(q, 32'h2, "no carrier");
    check(vsig_rises - base, 6, "vco pulses");
    $display("test playback done");
  endtask : t_play

  task automatic t_div();
    repeat (100) @(posedge clk);
    check(pref_gap, 8 * 5, "div gap");
    repeat (40) @(posedge clk);
    check(pref_gap, 8 * 5, "div gap 2");
    $display("test divider done");
  endtask : t_div

  // Reset in mid-run must drop a live audio record setup
  task automatic t_rerst();
    logic [31:0] q;
    wr(tfc_pkg::ADDR_CTRL, 32'hce, 4'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    rd(tfc_pkg::ADDR_CTRL, q);
    check(q, 32'h0, "ctrl after reset");
    $display("test mid reset done");
  endtask : t_rerst

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_audio();
    t_enc();
    t_play();
    t_div();
    t_rerst();
    results();
  end
endmodule : tfc_top_tb
`default_nettype wire
